// [tff_top.sv]
// Top: register port and three timer output flip-flops
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module tff_top
  import tff_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] pair_mode,
  input wire logic timer_p0_lo_match,
  input wire logic timer_p0_hi_match,
  input wire logic timer_p1_lo_match,
  input wire logic timer_p1_hi_match,
  input wire logic timer_p2_lo_match,
  input wire logic timer_p2_hi_match,
  input wire logic [2:0] pin_timer_func,
  input wire logic [2:0] pin_port_data,
  output logic out_flop_a,
  output logic out_flop_b,
  output logic out_flop_c,
  output logic timer_out_pin_a,
  output logic timer_out_pin_b,
  output logic timer_out_pin_c
);
  import tff_pkg::*;

  logic [2:0] hit;
  logic [2:0] flop;
  logic [2:0] pin_out;
  logic [2:0] m_lo, m_hi;
  logic [3:0] ctrl [TFF_NUM];
  logic [7:0] rdata_d, rdata_q;

  assign hit[0] = (reg_addr == TFF_FF1_CTRL_OFF);
  assign hit[1] = (reg_addr == TFF_FF3_CTRL_OFF);
  assign hit[2] = (reg_addr == TFF_FF5_CTRL_OFF);
  assign m_lo = {timer_p2_lo_match, timer_p1_lo_match, timer_p0_lo_match};
  assign m_hi = {timer_p2_hi_match, timer_p1_hi_match, timer_p0_hi_match};

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  for (genvar i = 0; i < TFF_NUM; i++) begin : g_flop
    tff_flop u_flop (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .wr_stb(reg_wr && hit[i]),
      .wr_data(reg_wdata),
      .pair_mode(pair_mode[2*i+1 -: 2]),
      .match_lo(m_lo[i]),
      .match_hi(m_hi[i]),
      .ctrl_rd(ctrl[i]),
      .flop_q(flop[i])
    );
    // Pin shows the flop only while the port is in timer function
    assign pin_out[i] = pin_timer_func[i] ? flop[i] : pin_port_data[i];
  end

  assign out_flop_a = flop[0];
  assign out_flop_b = flop[1];
  assign out_flop_c = flop[2];
  assign timer_out_pin_a = pin_out[0];
  assign timer_out_pin_b = pin_out[1];
  assign timer_out_pin_c = pin_out[2];

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = TFF_UNMAPPED_READ;
    if (reg_rd) begin
      if (hit[0]) begin
        rdata_d = {TFF_UPPER_READ, ctrl[0]};
      end else if (hit[1]) begin
        rdata_d = {TFF_UPPER_READ, ctrl[1]};
      end else if (hit[2]) begin
        rdata_d = {TFF_UPPER_READ, ctrl[2]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= TFF_UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// [tff_pkg.sv]
// Package: register map, field layout and reset values for the timer flip-flop control
package tff_pkg;
  localparam logic [8:0] TFF_ADDR_W = 9'h009;
  localparam logic [8:0] TFF_FF1_CTRL_OFF = 9'h105;
  localparam logic [8:0] TFF_FF3_CTRL_OFF = 9'h10d;
  localparam logic [8:0] TFF_FF5_CTRL_OFF = 9'h115;
  localparam int TFF_NUM = 3;
  // Field positions inside a control byte
  localparam int TFF_SEL_BIT = 0;
  localparam int TFF_EN_BIT = 1;
  localparam int TFF_SW_LO = 2;
  localparam int TFF_SW_HI = 3;
  // Software control encodings
  localparam logic [1:0] TFF_SW_INVERT = 2'h0;
  localparam logic [1:0] TFF_SW_SET = 2'h1;
  localparam logic [1:0] TFF_SW_CLEAR = 2'h2;
  localparam logic [1:0] TFF_SW_KEEP = 2'h3;
  // Pair operating mode encoding that makes the select bit meaningful
  localparam logic [1:0] TFF_MODE_8BIT = 2'h0;
  // Reset values and unimplemented bits
  localparam logic [1:0] TFF_SW_RESET = 2'h3;
  localparam logic TFF_EN_RESET = 1'b0;
  localparam logic TFF_SEL_RESET = 1'b0;
  localparam logic TFF_FLOP_RESET = 1'b0;
  localparam logic [3:0] TFF_UPPER_READ = 4'hf;
  localparam logic [7:0] TFF_UNMAPPED_READ = 8'h00;
endpackage

// [tff_flop.sv]
// One timer output flip-flop with its control fields and toggle source selection
`timescale 1ns/1ps
module tff_flop
  import tff_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] pair_mode,
  input wire logic match_lo,
  input wire logic match_hi,
  output logic [3:0] ctrl_rd,
  output logic flop_q
);
  logic en_q, en_d, sel_q, sel_d, flop_d, match_sel;
  logic [1:0] sw_q, sw_d;

  // Outside 8-bit mode the pair counts as one timer, so only the upper match can toggle
  always_comb begin
    if (pair_mode == TFF_MODE_8BIT) begin
      match_sel = sel_q ? match_hi : match_lo;
    end else begin
      match_sel = match_hi;
    end
  end

  always_comb begin
    en_d = en_q;
    sel_d = sel_q;
    sw_d = sw_q;
    flop_d = flop_q;
    if (en_q && match_sel) begin
      flop_d = ~flop_q;
    end
    // A software write acts after the match, so its invert, set or clear code wins a tie; the keep code lets the match toggle through
    if (wr_stb) begin
      en_d = wr_data[TFF_EN_BIT];
      sel_d = wr_data[TFF_SEL_BIT];
      sw_d = wr_data[TFF_SW_HI:TFF_SW_LO];
      case (wr_data[TFF_SW_HI:TFF_SW_LO])
        TFF_SW_INVERT: flop_d = ~flop_q;
        TFF_SW_SET: flop_d = 1'b1;
        TFF_SW_CLEAR: flop_d = 1'b0;
        default: flop_d = flop_d;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_q <= TFF_EN_RESET;
      sel_q <= TFF_SEL_RESET;
      sw_q <= TFF_SW_RESET;
      flop_q <= TFF_FLOP_RESET;
    end else begin
      en_q <= en_d;
      sel_q <= sel_d;
      sw_q <= sw_d;
      flop_q <= flop_d;
    end
  end

  assign ctrl_rd = {sw_q, en_q, sel_q};
endmodule

// [tff_top_asserts.sv]
// Port-level checker for the timer flip-flop block
`timescale 1ns/1ps
module tff_chk (
  input wire logic clk_sys, nrst, reg_wr, reg_rd, out_flop_a, out_flop_b, out_flop_c,
  input wire logic timer_p0_lo_match, timer_p0_hi_match, timer_p1_lo_match,
  input wire logic timer_p1_hi_match, timer_p2_lo_match, timer_p2_hi_match,
  input wire logic timer_out_pin_a,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [5:0] pair_mode,
  input wire logic [2:0] pin_timer_func
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_SW: assert property (reg_wr && reg_addr == 9'h105 && ^reg_wdata[3:2]
    |=> out_flop_a == $past(reg_wdata[2])) else $error("sw");
  AST_TA: assert property (!reg_wr && !timer_p0_lo_match && !timer_p0_hi_match
    |=> $stable(out_flop_a)) else $error("a");
  AST_TB: assert property (!reg_wr && !timer_p1_lo_match && !timer_p1_hi_match
    |=> $stable(out_flop_b)) else $error("b");
  AST_TC: assert property (!reg_wr && !timer_p2_lo_match && !timer_p2_hi_match
    |=> $stable(out_flop_c)) else $error("c");
  // Outside 8-bit mode only the upper timer's match may toggle
  AST_MD: assert property (pair_mode[1:0] != 0 && !reg_wr && !timer_p0_hi_match
    |=> $stable(out_flop_a)) else $error("md");
  AST_UP: assert property (reg_rd && reg_addr == 9'h105 |=> reg_rdata[7:4] == 4'hf)
    else $error("up");
  AST_PIN: assert property (pin_timer_func[0] |-> timer_out_pin_a == out_flop_a)
    else $error("pin");
  cover property (timer_p0_hi_match && out_flop_a);
  cover property (reg_rd && reg_addr == 9'h105);
  cover property (pair_mode != 0 && timer_p0_lo_match);
endmodule
bind tff_top tff_chk u_chk (.*);

// [tff_top_tb.sv]
// Self-checking bench for the timer flip-flop block
`timescale 1ns/1ps
module tff_top_tb;
  logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [8:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [5:0] pair_mode = 0, m = 0;
  logic [2:0] pin_timer_func = 0, pin_port_data = 0, f, p;
  int miscompares = 0, check_count = 0;
  tff_top uut (.*, .timer_p0_lo_match(m[0]), .timer_p0_hi_match(m[1]),
    .timer_p1_lo_match(m[2]), .timer_p1_hi_match(m[3]), .timer_p2_lo_match(m[4]),
    .timer_p2_hi_match(m[5]), .out_flop_a(f[0]), .out_flop_b(f[1]), .out_flop_c(f[2]),
    .timer_out_pin_a(p[0]), .timer_out_pin_b(p[1]), .timer_out_pin_c(p[2]));
  initial forever #4 clk_sys = ~clk_sys;
  task ck(logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %h %h", $time, g, e);
    end
  endtask
  // Write compares the flops afterwards, read compares the returned byte
  task io(bit w, logic [8:0] a, logic [7:0] d, e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 0;
    reg_rd <= 0;
    #1 ck(w ? {5'h0, f} : reg_rdata, e);
  endtask
  task mt(int i, logic [7:0] e);
    @(posedge clk_sys);
    m <= 6'h01 << i;
    @(posedge clk_sys);
    m <= 0;
    #1 ck({5'h0, f}, e);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1;
    io(0, 9'h105, 0, 8'hfc);
    io(0, 9'h100, 0, 8'h00);
    io(1, 9'h105, 8'h07, 8'h01);
    io(1, 9'h105, 8'h03, 8'h00);
    io(1, 9'h105, 8'h0b, 8'h00);
    io(0, 9'h105, 0, 8'hfb);
    $display("register test done");
    mt(1, 8'h01);
    mt(0, 8'h01);
    pair_mode <= 6'h01;
    mt(0, 8'h01);
    pair_mode <= 6'h00;
    io(1, 9'h10d, 8'h0a, 8'h01);
    mt(2, 8'h03);
    io(1, 9'h10d, 8'h0c, 8'h03);
    mt(2, 8'h03);
    io(1, 9'h115, 8'h0a, 8'h03);
    mt(4, 8'h07);
    pin_timer_func <= 3'h5;
    #8 ck({5'h0, p}, 8'h05);
    pin_timer_func <= 3'h0;
    pin_port_data <= 3'h2;
    #8 ck({5'h0, p}, 8'h02);
    $display("toggle test done");
    close_out;
  end
  initial begin
    #3000;
    miscompares++;
    close_out;
  end
endmodule
